// ---- inc/smg_pkg.sv ----
package smg_pkg;

	// ----------------------------------------
	// Sizes and counts
	// ----------------------------------------
	localparam int         SMG_NCH      = 2;
	localparam int         SMG_AW       = 8;
	localparam int         SMG_DEPTH    = 256;
	localparam int         SMG_FIFO_D   = 4;
	localparam int         SMG_DW       = 8;
	localparam logic [7:0] SMG_DIST_MAX = 8'hff;
	localparam logic [7:0] SMG_DIST_ONE = 8'h01;
	localparam logic [7:0] SMG_DIST_64G = 8'h80;
	localparam logic [7:0] SMG_DIST_32G = 8'h40;
	localparam logic [7:0] SMG_DIST_16G = 8'h20;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		SMG_RATE_64G = 2'b00,
		SMG_RATE_32G = 2'b01,
		SMG_RATE_16G = 2'b10
	} smg_rate_t;

	typedef enum logic [0:0]
	{
		SMG_IDLE = 1'b0,
		SMG_RUN  = 1'b1
	} smg_state_t;

	typedef struct packed
	{
		logic                 first;
		logic [SMG_AW-1:0]    addr;
		logic [SMG_NCH-1:0]   mark;
	} smg_sample_t;

	typedef struct packed
	{
		logic [SMG_AW-1:0]    addr;
		logic [SMG_NCH-1:0]   rise;
		logic [SMG_NCH-1:0]   fall;
	} smg_edge_t;

	// ----------------------------------------
	// Least same-polarity spacing per rate
	// ----------------------------------------
	function automatic logic [7:0] smg_min_dist(input smg_rate_t rate);
		case (rate)
			SMG_RATE_64G: smg_min_dist = SMG_DIST_64G;
			SMG_RATE_32G: smg_min_dist = SMG_DIST_32G;
			SMG_RATE_16G: smg_min_dist = SMG_DIST_16G;
			default:      smg_min_dist = SMG_DIST_64G;
		endcase
	endfunction : smg_min_dist

endpackage : smg_pkg

// ---- core/smg_marker_gen.sv ----
// Contract
// - Two marker outputs are produced, each locked to the played sample stream.
// - Marker flags are turned into rising and falling edges before playback.
// - Edge positions are kept in a marker memory that drives the outputs.
// - The spacing is 128, 64 or 32 samples for 64, 32 or 16 GSa/s access rates.
// - Edges are found per segment, with no detection across segment boundaries.
// - Each segment start gets an edge of the first flag's polarity, barring that polarity for the rate's spacing after.
// - Every separately loaded portion is converted alone with its own leading edge.
// - Playback from an offset ignores edges stored outside the played range.
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Edge word buffer
// ----------------------------------------
module smg_fifo #(
	parameter int W = 12,
	parameter int D = 4
) (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int PW = $clog2(D);

	logic [W-1:0]  mem_reg [D];
	logic [PW-1:0] wp_reg;
	logic [PW-1:0] rp_reg;
	logic [PW:0]   cnt_reg;
	logic          push;
	logic          pop;

	assign in_ready_o  = (cnt_reg != (PW+1)'(D));
	assign out_valid_o = (cnt_reg != '0);
	assign out_data_o  = mem_reg[rp_reg];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i)
	begin
		if (push)
		begin
			mem_reg[wp_reg] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			if (push)
			begin
				wp_reg <= (wp_reg == PW'(D - 1)) ? '0 : wp_reg + 1'b1;
			end
			if (pop)
			begin
				rp_reg <= (rp_reg == PW'(D - 1)) ? '0 : rp_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule : smg_fifo

// ----------------------------------------
// Marker edge generator
// ----------------------------------------
module smg_marker_gen
	import smg_pkg::*;
(
	input  wire logic               clk_i,
	input  wire logic               resetn_i,
	input  wire logic               ld_valid_i,
	output logic                    ld_ready_o,
	input  wire smg_sample_t        ld_data_i,
	input  wire smg_rate_t          rate_i,
	input  wire logic               play_start_i,
	input  wire logic [SMG_AW-1:0]  play_off_i,
	input  wire logic [SMG_AW:0]    play_len_i,
	output logic                    play_busy_o,
	output logic                    smp_valid_o,
	output logic [SMG_AW-1:0]       smp_addr_o,
	output logic [SMG_NCH-1:0]      marker_o,
	output logic                    dens_viol_o
);
	// ----------------------------------------
	// Conversion of flags into edges
	// ----------------------------------------
	logic [SMG_NCH-1:0] prev_reg;
	logic [SMG_NCH-1:0] rise_raw;
	logic [SMG_NCH-1:0] fall_raw;
	logic [SMG_NCH-1:0] rise_ok;
	logic [SMG_NCH-1:0] fall_ok;
	logic [7:0]         dist_r_reg [SMG_NCH];
	logic [7:0]         dist_f_reg [SMG_NCH];
	logic [7:0]         min_dist;
	logic               ld_fire;
	logic               fifo_in_ready;
	logic               viol_reg;
	smg_edge_t          edge_in;
	smg_edge_t          edge_out;
	logic               edge_valid;
	logic               edge_ready;

	assign min_dist   = smg_min_dist(rate_i);
	assign ld_ready_o = fifo_in_ready;
	assign ld_fire    = ld_valid_i && fifo_in_ready;

	genvar ch;
	generate
		for (ch = 0; ch < SMG_NCH; ch++)
		begin : g_conv
			// First sample of a segment or portion forces an edge
			assign rise_raw[ch] = ld_data_i.first ? ld_data_i.mark[ch]
				: (ld_data_i.mark[ch] && !prev_reg[ch]);
			assign fall_raw[ch] = ld_data_i.first ? !ld_data_i.mark[ch]
				: (!ld_data_i.mark[ch] && prev_reg[ch]);
			assign rise_ok[ch]  = rise_raw[ch]
				&& (ld_data_i.first || dist_r_reg[ch] >= min_dist);
			assign fall_ok[ch]  = fall_raw[ch]
				&& (ld_data_i.first || dist_f_reg[ch] >= min_dist);

			always_ff @(posedge clk_i or negedge resetn_i)
			begin
				if (!resetn_i)
				begin
					prev_reg[ch]   <= 1'b0;
					dist_r_reg[ch] <= SMG_DIST_MAX;
					dist_f_reg[ch] <= SMG_DIST_MAX;
				end
				else if (ld_fire)
				begin
					prev_reg[ch] <= ld_data_i.mark[ch];
					if (rise_ok[ch])
					begin
						dist_r_reg[ch] <= SMG_DIST_ONE;
					end
					else if (ld_data_i.first || dist_r_reg[ch] != SMG_DIST_MAX)
					begin
						dist_r_reg[ch] <= ld_data_i.first ? SMG_DIST_MAX : dist_r_reg[ch] + 8'h01;
					end
					if (fall_ok[ch])
					begin
						dist_f_reg[ch] <= SMG_DIST_ONE;
					end
					else if (ld_data_i.first || dist_f_reg[ch] != SMG_DIST_MAX)
					begin
						dist_f_reg[ch] <= ld_data_i.first ? SMG_DIST_MAX : dist_f_reg[ch] + 8'h01;
					end
				end
			end
		end
	endgenerate

	// Dropped too-close edge flagged for one cycle
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			viol_reg <= 1'b0;
		end
		else
		begin
			viol_reg <= ld_fire && (((rise_raw & ~rise_ok) | (fall_raw & ~fall_ok)) != '0);
		end
	end
	assign dens_viol_o = viol_reg;

	assign edge_in.addr = ld_data_i.addr;
	assign edge_in.rise = rise_ok;
	assign edge_in.fall = fall_ok;

	smg_fifo #(
		.W ($bits(smg_edge_t)),
		.D (SMG_FIFO_D)
	) u_fifo (
		.clk_i       (clk_i),
		.resetn_i    (resetn_i),
		.in_valid_i  (ld_valid_i),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (edge_in),
		.out_valid_o (edge_valid),
		.out_ready_i (edge_ready),
		.out_data_o  (edge_out)
	);

	// ----------------------------------------
	// Marker memory
	// ----------------------------------------
	logic [2*SMG_NCH-1:0] mmem [SMG_DEPTH];
	smg_state_t           state_reg;
	logic [SMG_AW-1:0]    addr_reg;
	logic [SMG_AW:0]      left_reg;
	logic [2*SMG_NCH-1:0] rd_word;

	// Stall a write to the word being played
	assign edge_ready = !(state_reg == SMG_RUN && addr_reg == edge_out.addr);
	assign rd_word    = mmem[addr_reg];

	always_ff @(posedge clk_i)
	begin
		if (edge_valid && edge_ready)
		begin
			mmem[edge_out.addr] <= {edge_out.rise, edge_out.fall};
		end
	end

	// ----------------------------------------
	// Playback
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_reg <= SMG_IDLE;
			addr_reg  <= '0;
			left_reg  <= '0;
		end
		else
		begin
			case (state_reg)
				SMG_IDLE:
				begin
					if (play_start_i && play_len_i != '0)
					begin
						state_reg <= SMG_RUN;
						addr_reg  <= play_off_i;
						left_reg  <= play_len_i;
					end
				end
				SMG_RUN:
				begin
					addr_reg <= addr_reg + 1'b1;
					left_reg <= left_reg - 1'b1;
					if (left_reg == 9'h001)
					begin
						state_reg <= SMG_IDLE;
					end
				end
				default:
				begin
					state_reg <= SMG_IDLE;
				end
			endcase
		end
	end
	assign play_busy_o = (state_reg == SMG_RUN);

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			smp_valid_o <= 1'b0;
			smp_addr_o  <= '0;
		end
		else
		begin
			smp_valid_o <= (state_reg == SMG_RUN);
			smp_addr_o  <= addr_reg;
		end
	end

	generate
		for (ch = 0; ch < SMG_NCH; ch++)
		begin : g_out
			always_ff @(posedge clk_i or negedge resetn_i)
			begin
				if (!resetn_i)
				begin
					marker_o[ch] <= 1'b0;
				end
				else if (play_busy_o && rd_word[SMG_NCH+ch])
				begin
					marker_o[ch] <= 1'b1;
				end
				else if (play_busy_o && rd_word[ch])
				begin
					marker_o[ch] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule : smg_marker_gen

`default_nettype wire

// ---- bench/smg_marker_gen_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module smg_chk
	import smg_pkg::*;
(
	input wire logic               clk_i,
	input wire logic               resetn_i,
	input wire logic               ld_valid_i,
	input wire logic               ld_ready_o,
	input wire logic               play_start_i,
	input wire logic [SMG_AW-1:0]  play_off_i,
	input wire logic [SMG_AW:0]    play_len_i,
	input wire logic               play_busy_o,
	input wire logic               smp_valid_o,
	input wire logic [SMG_AW-1:0]  smp_addr_o,
	input wire logic [SMG_NCH-1:0] marker_o,
	input wire logic               dens_viol_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	wire logic go = play_start_i && !play_busy_o && play_len_i != '0;
	a_start_valid: assert property (go |=> play_busy_o ##1 smp_valid_o)
		else $error("no sample after start");
	a_valid_busy: assert property (smp_valid_o == $past(play_busy_o))
		else $error("sample not one cycle after busy");
	a_len_one: assert property (go && play_len_i == 9'h001
		|=> play_busy_o ##1 !play_busy_o)
		else $error("single position play wrong length");
	a_len_zero: assert property (play_start_i && !play_busy_o && play_len_i == '0
		|=> !play_busy_o)
		else $error("empty play started");
	a_first_addr: assert property (go |-> ##2 smp_addr_o == $past(play_off_i, 2))
		else $error("first address not offset");
	a_addr_step: assert property (smp_valid_o && $past(smp_valid_o)
		|-> smp_addr_o == $past(smp_addr_o) + 8'h01)
		else $error("address not ascending");
	a_marker_hold: assert property (!smp_valid_o |-> $stable(marker_o))
		else $error("marker moved without sample");
	a_viol_cause: assert property (dens_viol_o |-> $past(ld_valid_i && ld_ready_o))
		else $error("density flag without load");
endmodule : smg_chk
bind smg_marker_gen smg_chk u_chk (.clk_i, .resetn_i, .ld_valid_i, .ld_ready_o, .play_start_i,
	.play_off_i, .play_len_i, .play_busy_o, .smp_valid_o, .smp_addr_o, .marker_o, .dens_viol_o);
`default_nettype wire

// ---- bench/smg_mark_rx.sv ----
`timescale 1ns/10ps
`default_nettype none
module smg_mark_rx
	import smg_pkg::*;
(
	input wire logic               clk_i,
	input wire logic               valid_i,
	input wire logic [SMG_AW-1:0]  addr_i,
	input wire logic [SMG_NCH-1:0] mark_i
);
	logic [SMG_NCH-1:0] lvl [SMG_DEPTH];
	int                 n = 0;
	always @(posedge clk_i)
	begin
		if (valid_i === 1'b1)
		begin
			lvl[addr_i] <= mark_i;
			n <= n + 1;
		end
	end
endmodule : smg_mark_rx
`default_nettype wire

// ---- bench/test_smg_marker_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_smg_marker_gen
	import smg_pkg::*;
;
	logic        clk_i, resetn_i, ld_valid_i, ld_ready_o, play_start_i;
	logic        play_busy_o, smp_valid_o, dens_viol_o;
	smg_sample_t ld_data_i;
	smg_rate_t   rate_i;
	logic [7:0]  play_off_i, smp_addr_o;
	logic [8:0]  play_len_i;
	logic [1:0]  marker_o;
	int          n_errors = 0, compares = 0, nv = 0;
	smg_marker_gen dut (.clk_i, .resetn_i, .ld_valid_i, .ld_ready_o, .ld_data_i, .rate_i,
		.play_start_i, .play_off_i, .play_len_i, .play_busy_o, .smp_valid_o, .smp_addr_o,
		.marker_o, .dens_viol_o);
	smg_mark_rx rx (.clk_i, .valid_i(smp_valid_o), .addr_i(smp_addr_o), .mark_i(marker_o));
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
		if (dens_viol_o === 1'b1) nv++;
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic step(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask : step
	task automatic load(input logic f, input logic [7:0] a, input logic [1:0] m);
		ld_valid_i = 1'b1;
		ld_data_i = {f, a, m};
		for (int t = 0; t < 20 && ld_ready_o !== 1'b1; t++) step(1);
		step(1);
	endtask : load
	task automatic play(input logic [7:0] o, input logic [8:0] l);
		int n0;
		ld_valid_i = 1'b0;
		step(6);
		n0 = rx.n;
		play_off_i = o;
		play_len_i = l;
		play_start_i = 1'b1;
		step(2);
		play_start_i = 1'b0;
		for (int t = 0; t < 300 && play_busy_o !== 1'b0; t++) step(1);
		step(2);
		chk(16'(rx.n - n0), 16'(l));
	endtask : play
	task automatic t_edges();
		for (int a = 0; a < 40; a++) load(a == 0, 8'(a), {a >= 20, a < 10});
		play(8'h00, 9'h028);
		for (int a = 0; a < 40; a++) chk(rx.lvl[a], {a >= 20, a < 10});
	endtask : t_edges
	task automatic t_dens();
		logic [7:0] d;
		int         v;
		for (int r = 0; r < 4; r++)
		begin
			rate_i = smg_rate_t'(r);
			d = (r == 1) ? SMG_DIST_32G : (r == 2) ? SMG_DIST_16G : SMG_DIST_64G;
			v = nv;
			for (int i = 0; i < d + 2; i++) load(i == 0, 8'(100 + i), {i != 1, i == 0 || i == d});
			play(8'h64, 9'(d + 2));
			chk(16'(nv - v), 16'h0001);
			for (int i = 0; i < d + 2; i++) chk(rx.lvl[100 + i], {i == 0, i == 0 || i == d});
		end
	endtask : t_dens
	task automatic t_parts();
		for (int i = 0; i < 20; i++) load(i % 10 == 0, 8'(50 + i), {2{i > 0 && i < 15}});
		play(8'h3c, 9'h00a);
		for (int i = 0; i < 10; i++) chk(rx.lvl[60 + i], {2{i < 5}});
		play(8'h3e, 9'h001);
		chk(rx.lvl[62], 16'h0000);
		play(8'h3e, 9'h000);
	endtask : t_parts
	task automatic final_report();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	initial
	begin
		resetn_i = 1'b0;
		ld_valid_i = 1'b0;
		ld_data_i = '0;
		rate_i = SMG_RATE_16G;
		play_start_i = 1'b0;
		play_off_i = 8'h00;
		play_len_i = 9'h000;
		step(4);
		resetn_i = 1'b1;
		t_edges();
		t_dens();
		t_parts();
		final_report();
	end
	initial
	begin
		#100us;
		n_errors++;
		final_report();
	end
endmodule : test_smg_marker_gen
`default_nettype wire
